// file: hw/csf_pkg.sv
// Package of constants for the codec status flag register group.
// Assumes an APB master with 32-bit data; registers sit at four times their index.
package csf_pkg;

    // ==========================================================
    // Bus and register indices
    localparam int          APB_AW      = 12;
    localparam logic [7:0]  IDX_PWR     = 8'h5E;
    localparam logic [7:0]  IDX_SHORT   = 8'h5F;
    localparam logic [7:0]  IDX_STICKY  = 8'h60;
    localparam logic [7:0]  IDX_LIVE    = 8'h61;
    localparam logic [7:0]  IDX_CTRL    = 8'h63;
    localparam logic [7:0]  IDX_BTN_CLR = 8'h0E;

    // ==========================================================
    // Field positions
    localparam int P_LDAC  = 7;
    localparam int P_RDAC  = 6;
    localparam int P_MONO  = 5;
    localparam int P_LLO   = 4;
    localparam int P_RLO   = 3;
    localparam int P_HPL   = 2;
    localparam int P_HPR   = 1;
    localparam int S_LCOM  = 3;
    localparam int S_RCOM  = 2;
    localparam int F_SCHI  = 7;
    localparam int F_SCLO  = 4;
    localparam int F_BTN   = 3;
    localparam int F_HS    = 2;
    localparam int F_NGL   = 1;
    localparam int F_NGR   = 0;
    localparam int C_CONT  = 0;

    // ==========================================================
    // Reset values and timing
    localparam logic [7:0]  STATUS_RST          = 8'h00;
    localparam logic [31:0] RDATA_RST           = 32'h0000_0000;
    localparam int          CLK_MHZ             = 10;
    localparam int          IRQ_PULSE_PERIOD_US = 1000;
    localparam int          CNT_W               = 14;

    // Byte address of a register index
    function automatic logic [APB_AW-1:0] csf_byte_addr(input logic [7:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction

    function automatic logic csf_hit(input logic [APB_AW-1:0] a, input logic [7:0] idx);
        return a == csf_byte_addr(idx);
    endfunction

endpackage

// file: hw/csf_sync.sv
// Two-flop synchroniser bank for status levels.
// Assumes the inputs are asynchronous levels from the analog side.
`timescale 1ns/10ps
module csf_sync #(
    parameter int W = 17
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] m1;
        logic [W-1:0] m2;
    } csf_sync_t;

    csf_sync_t s_q;
    csf_sync_t s_d;

    always_comb begin
        s_d    = s_q;
        s_d.m1 = d;
        s_d.m2 = s_q.m1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q.m2;
endmodule // csf_sync

// file: hw/csf_status_flags.sv
// Status and event flag registers of a stereo codec, reached over APB.
// Assumes asynchronous status levels from analog detectors; one 10 MHz clock.
`timescale 1ns/10ps
// Operation
// (RULE1) Power register bit 7 shows left DAC fully powered.
// (RULE2) Power register bit 6 shows right DAC fully powered.
// (RULE3) Power register bit 5 shows mono line driver powered up.
// (RULE4) Power register bit 4 shows left line driver powered up.
// (RULE5) Power register bit 3 shows right line output fully powered.
// (RULE6) Power bits 2 and 1 show left and right headphone drivers powered.
// (RULE7) Host leaves reserved power bit 0 unwritten.
// (RULE8) Short register bits 7..4 show shorts on the four drivers.
// (RULE9) Short register bits 3 and 2 show common drivers powered.
// (RULE10) Host leaves short register bits 1..0 alone; they read zero.
// (RULE11) Sticky register latches driver shorts in bits 7..4.
// (RULE12) Sticky bit 2 sets on headset insertion or removal.
// (RULE13) Sticky bit 3 sets on a headset button press.
// (RULE14) Bits 1 and 0 show left and right noise gate conditions.
// (RULE15) Live register bits 7..4 and noise bits track present state.
// (RULE16) Live bit 2 shows a headset currently present.
// (RULE17) Live button bit stays set until the button clear register is read.
// (RULE18) Continuous mode pulses the interrupt until the sticky register is read.
// (RULE19) Status registers are read-only, ignore writes, read zero after reset.
// (RULE20) Reading the sticky register clears its latched bits, then relatches.
module csf_status_flags
    import csf_pkg::*;
#(
    parameter int unsigned IRQ_PULSE_CYCLES = IRQ_PULSE_PERIOD_US * CLK_MHZ
) (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst,
    // APB slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [csf_pkg::APB_AW-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    // Power state levels
    input  wire logic                       left_dac_pwr,
    input  wire logic                       right_dac_pwr,
    input  wire logic                       mono_diff_line_out_pwr,
    input  wire logic                       left_diff_line_out_pwr,
    input  wire logic                       right_diff_line_out_pwr,
    input  wire logic                       left_headphone_driver_pwr,
    input  wire logic                       right_headphone_driver_pwr,
    input  wire logic                       left_common_driver_pwr,
    input  wire logic                       right_common_driver_pwr,
    // Short circuit levels
    input  wire logic                       left_headphone_driver_short,
    input  wire logic                       right_headphone_driver_short,
    input  wire logic                       left_common_driver_short,
    input  wire logic                       right_common_driver_short,
    // Headset, button and noise gate levels
    input  wire logic                       headset_present,
    input  wire logic                       button_pressed,
    input  wire logic                       left_noise_gate,
    input  wire logic                       right_noise_gate,
    // Interrupt pulse train
    output logic                            irq_pulse
);
    import csf_pkg::*;

    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(IRQ_PULSE_CYCLES - 1);

    // ==========================================================
    // Synchronised inputs
    logic       sy_ldac;
    logic       sy_rdac;
    logic       sy_mono;
    logic       sy_llo;
    logic       sy_rlo;
    logic       sy_hpl;
    logic       sy_hpr;
    logic       sy_lcom;
    logic       sy_rcom;
    logic [3:0] sy_short;
    logic       sy_hs;
    logic       sy_btn;
    logic       sy_ngl;
    logic       sy_ngr;
    logic [16:0] sync_q;

    csf_sync #(
        .W (17)
    ) csf_sync_inst (
        .clk (clk),
        .rst (rst),
        .d   ({left_dac_pwr, right_dac_pwr, mono_diff_line_out_pwr,
               left_diff_line_out_pwr, right_diff_line_out_pwr,
               left_headphone_driver_pwr, right_headphone_driver_pwr,
               left_common_driver_pwr, right_common_driver_pwr,
               left_headphone_driver_short, right_headphone_driver_short,
               left_common_driver_short, right_common_driver_short,
               headset_present, button_pressed, left_noise_gate,
               right_noise_gate}),
        .q   (sync_q)
    );

    assign {sy_ldac, sy_rdac, sy_mono, sy_llo, sy_rlo, sy_hpl, sy_hpr,
            sy_lcom, sy_rcom, sy_short, sy_hs, sy_btn, sy_ngl, sy_ngr} = sync_q;

    // ==========================================================
    // State
    typedef struct packed {
        logic             hs_prev;
        logic             btn_prev;
        logic [7:0]       sticky;
        logic             live_btn;
        logic [31:0]      rdata;
        logic             err;
        logic             cont;
        logic             train;
        logic [CNT_W-1:0] cnt;
        logic             irq;
    } csf_state_t;

    csf_state_t s_q;
    csf_state_t s_d;

    logic       setup;
    logic       rd_done;
    logic       wr_done;
    logic       rd_sticky;
    logic       rd_btn_clr;
    logic       btn_rise;
    logic       hs_edge;
    logic [7:0] pwr_word;
    logic [7:0] short_word;
    logic [7:0] live_word;
    logic [7:0] sticky_set;
    logic [7:0] clr_mask;
    logic [7:0] kept;
    logic       mapped;

    assign setup      = psel && !penable;
    assign rd_done    = psel && penable && !pwrite;
    assign wr_done    = psel && penable && pwrite;
    assign rd_sticky  = rd_done && csf_hit(paddr, IDX_STICKY);
    assign rd_btn_clr = rd_done && csf_hit(paddr, IDX_BTN_CLR);
    assign btn_rise   = sy_btn && !s_q.btn_prev;
    assign hs_edge    = sy_hs ^ s_q.hs_prev;
    assign mapped     = csf_hit(paddr, IDX_PWR) || csf_hit(paddr, IDX_SHORT)
                     || csf_hit(paddr, IDX_STICKY) || csf_hit(paddr, IDX_LIVE)
                     || csf_hit(paddr, IDX_CTRL) || csf_hit(paddr, IDX_BTN_CLR);

    // ==========================================================
    // Next state
    always_comb begin
        s_d = s_q;

        pwr_word         = STATUS_RST;
        pwr_word[P_LDAC] = sy_ldac; // RULE1
        pwr_word[P_RDAC] = sy_rdac; // RULE2
        pwr_word[P_MONO] = sy_mono; // RULE3
        pwr_word[P_LLO]  = sy_llo; // RULE4
        pwr_word[P_RLO]  = sy_rlo; // RULE5
        pwr_word[P_HPL]  = sy_hpl; // RULE6
        pwr_word[P_HPR]  = sy_hpr; // RULE6

        short_word                = STATUS_RST;
        short_word[F_SCHI:F_SCLO] = sy_short; // RULE8
        short_word[S_LCOM]        = sy_lcom; // RULE9
        short_word[S_RCOM]        = sy_rcom; // RULE9

        live_word                = STATUS_RST;
        live_word[F_SCHI:F_SCLO] = sy_short; // RULE15
        live_word[F_BTN]         = s_q.live_btn;
        live_word[F_HS]          = sy_hs; // RULE16
        live_word[F_NGL]         = sy_ngl; // RULE14
        live_word[F_NGR]         = sy_ngr; // RULE14

        sticky_set                = STATUS_RST;
        sticky_set[F_SCHI:F_SCLO] = sy_short; // RULE11
        sticky_set[F_BTN]         = btn_rise; // RULE13
        sticky_set[F_HS]          = hs_edge; // RULE12
        sticky_set[F_NGL]         = sy_ngl; // RULE14
        sticky_set[F_NGR]         = sy_ngr; // RULE14

        // Clear only what was shown to the host; new events win
        clr_mask = rd_sticky ? s_q.rdata[7:0] : STATUS_RST; // RULE20
        kept     = s_q.sticky & ~clr_mask;
        s_d.sticky = kept | sticky_set; // RULE11

        s_d.hs_prev  = sy_hs;
        s_d.btn_prev = sy_btn;
        s_d.live_btn = (s_q.live_btn && !rd_btn_clr) || btn_rise; // RULE17

        // Read data and error are prepared in the setup phase
        if (setup) begin
            s_d.rdata = RDATA_RST;
            s_d.err   = !mapped;
            if (!pwrite) begin
                if (csf_hit(paddr, IDX_PWR)) begin
                    s_d.rdata[7:0] = pwr_word;
                end else if (csf_hit(paddr, IDX_SHORT)) begin
                    s_d.rdata[7:0] = short_word;
                end else if (csf_hit(paddr, IDX_STICKY)) begin
                    s_d.rdata[7:0] = s_q.sticky;
                end else if (csf_hit(paddr, IDX_LIVE)) begin
                    s_d.rdata[7:0] = live_word;
                end else if (csf_hit(paddr, IDX_CTRL)) begin
                    s_d.rdata[C_CONT] = s_q.cont;
                end
            end
        end

        // Status registers ignore writes; only control is writable
        if (wr_done && csf_hit(paddr, IDX_CTRL)) begin // RULE19
            s_d.cont = pwdata[C_CONT];
        end

        // Pulse train runs from a new latched event until the sticky read
        // A level still present after the read counts as new and keeps it running
        // Counter runs only while the train is on, so each train pulses at once
        s_d.train = ((s_q.train && !rd_sticky) || (|(sticky_set & ~kept)))
                    && s_q.cont; // RULE18
        if (s_q.train) begin
            s_d.cnt = (s_q.cnt == CNT_LAST) ? '0 : s_q.cnt + 1'b1;
        end else begin
            s_d.cnt = '0;
        end
        s_d.irq = s_q.train && (s_q.cnt == '0); // RULE18
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0; // RULE19
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata    = s_q.rdata;
    assign pready    = 1'b1;
    assign pslverr   = s_q.err;
    assign irq_pulse = s_q.irq;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_rd(logic [7:0] idx);
        psel && !penable && !pwrite && csf_hit(paddr, idx);
    endsequence

    sequence s_wr;
        psel && !penable && pwrite;
    endsequence

    sequence s_rd_done(logic [7:0] idx);
        psel && penable && !pwrite && csf_hit(paddr, idx);
    endsequence

    sequence s_sticky_read;
        s_rd(IDX_STICKY) ##1 s_rd_done(IDX_STICKY);
    endsequence

    AST_LDAC: assert property (s_rd(IDX_PWR) |=> prdata[P_LDAC] == $past(sy_ldac)) // RULE1
        else $error("left DAC power bit wrong");
    AST_RDAC: assert property (s_rd(IDX_PWR) |=> prdata[P_RDAC] == $past(sy_rdac)) // RULE2
        else $error("right DAC power bit wrong");
    AST_MONO: assert property (s_rd(IDX_PWR) |=> prdata[P_MONO] == $past(sy_mono)) // RULE3
        else $error("mono line power bit wrong");
    AST_LLO: assert property (s_rd(IDX_PWR) |=> prdata[P_LLO] == $past(sy_llo)) // RULE4
        else $error("left line power bit wrong");
    AST_RLO: assert property (s_rd(IDX_PWR) |=> prdata[P_RLO] == $past(sy_rlo)) // RULE5
        else $error("right line power bit wrong");
    AST_HP: assert property (s_rd(IDX_PWR)
            |=> prdata[2:0] == {$past(sy_hpl), $past(sy_hpr), 1'b0}) // RULE6
        else $error("headphone power bits wrong");
    AST_SHORT: assert property (s_rd(IDX_SHORT)
            |=> prdata[7:0] == {$past(sy_short), $past(sy_lcom), $past(sy_rcom), 2'h0}) // RULE8
        else $error("short register wrong");
    AST_COMPWR: assert property (s_rd(IDX_SHORT) ##1 prdata[S_LCOM] // RULE9
            |-> $past(sy_lcom))
        else $error("common power bit wrong");
    AST_STICKY_HOLD: assert property (s_q.sticky[F_SCHI] && !rd_sticky // RULE11
            |=> s_q.sticky[F_SCHI] [*1])
        else $error("latched short lost");
    AST_HS_EDGE: assert property ($changed(sy_hs) |=> s_q.sticky[F_HS]) // RULE12
        else $error("headset edge not latched");
    AST_BTN: assert property ($rose(sy_btn) |=> s_q.sticky[F_BTN] && s_q.live_btn) // RULE13
        else $error("button press not latched");
    AST_NG: assert property (s_rd(IDX_LIVE)
            |=> prdata[1:0] == {$past(sy_ngl), $past(sy_ngr)}) // RULE14
        else $error("noise gate bits wrong");
    AST_LIVE: assert property (s_rd(IDX_LIVE) |=> prdata[7:4] == $past(sy_short)) // RULE15
        else $error("live short bits wrong");
    AST_HS_LIVE: assert property (s_rd(IDX_LIVE) |=> prdata[F_HS] == $past(sy_hs)) // RULE16
        else $error("headset present bit wrong");
    AST_BTN_HOLD: assert property (s_q.live_btn && !rd_btn_clr |=> s_q.live_btn) // RULE17
        else $error("live button bit cleared early");
    AST_TRAIN: assert property ($rose(s_q.train) |=> irq_pulse ##1 !irq_pulse) // RULE18
        else $error("pulse train did not start");
    AST_TRAIN_STOP: assert property (rd_sticky && s_q.train && sticky_set == 8'h00
            |=> !s_q.train) // RULE18
        else $error("pulse train not stopped by read");
    AST_RO: assert property (s_wr |=> prdata == 32'h0000_0000) // RULE19
        else $error("write returned data");
    AST_CLR: assert property (rd_sticky && sticky_set == 8'h00
            |=> (s_q.sticky & $past(s_q.rdata[7:0])) == 8'h00) // RULE20
        else $error("sticky bits not cleared by read");

    // ==========================================================
    // Reserved bits, latching and pulse train checks
    AST_PWR_RSV: assert property (s_rd(IDX_PWR) // RULE19
            |=> prdata[31:8] == 24'h000000 && !prdata[0])
        else $error("power register reserved bits not zero");
    AST_SHORT_RSV: assert property (s_rd(IDX_SHORT) // RULE10
            |=> prdata[1:0] == 2'h0 && prdata[31:8] == 24'h000000)
        else $error("short register reserved bits not zero");
    AST_LIVE_RSV: assert property (s_rd(IDX_LIVE) // RULE15
            |=> prdata[31:8] == 24'h000000)
        else $error("live register upper bits not zero");
    AST_STICKY_SET: assert property (sy_short != 4'h0 // RULE11
            |=> (s_q.sticky[F_SCHI:F_SCLO] & $past(sy_short)) == $past(sy_short))
        else $error("short event not latched");
    AST_STICKY_RD: assert property (s_rd(IDX_STICKY) // RULE11
            |=> prdata[7:0] == $past(s_q.sticky))
        else $error("sticky register read wrong");
    AST_NG_STICKY: assert property (sy_ngl || sy_ngr // RULE14
            |=> (!$past(sy_ngl) || s_q.sticky[F_NGL]) && (!$past(sy_ngr) || s_q.sticky[F_NGR]))
        else $error("noise gate event not latched");
    AST_BTN_LIVE_RD: assert property (s_rd(IDX_LIVE) // RULE17
            |=> prdata[F_BTN] == $past(s_q.live_btn))
        else $error("live button bit read wrong");
    AST_BTN_CLR: assert property (s_rd_done(IDX_BTN_CLR) ##0 !btn_rise // RULE17
            |=> !s_q.live_btn)
        else $error("live button bit not cleared by read");
    AST_TRAIN_IDLE: assert property (!s_q.train |=> !irq_pulse) // RULE18
        else $error("pulse outside a train");
    AST_TRAIN_CONT: assert property (!s_q.cont |=> !s_q.train) // RULE18
        else $error("train running outside continuous mode");
    AST_WR_IGNORED: assert property (wr_done && sticky_set == 8'h00 // RULE19
            |=> s_q.sticky == $past(s_q.sticky) && s_q.live_btn == $past(s_q.live_btn))
        else $error("write changed a status flag");
    AST_CLR_SHOWN: assert property (s_sticky_read ##0 sticky_set == 8'h00 // RULE20
            |=> (s_q.sticky & $past(prdata[7:0])) == 8'h00)
        else $error("shown sticky bits survived the read");

endmodule // csf_status_flags

// file: tb/csf_host_model.sv
// Host side APB master model for the codec status flag registers.
// Assumes the bench calls its task from one process, one transfer at a time.
`timescale 1ns/10ps
module csf_host_model
    import csf_pkg::*;
(
    // Clock
    input  wire logic                       clk,
    // APB master
    output logic                            psel,
    output logic                            penable,
    output logic                            pwrite,
    output logic [csf_pkg::APB_AW-1:0]      paddr,
    output logic [31:0]                     pwdata,
    input  wire logic [31:0]                prdata,
    input  wire logic                       pready,
    input  wire logic                       pslverr
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = '0;
        pwdata  = '0;
    end

    // ==========================================================
    // One transfer: setup cycle, then access until pready
    task automatic xfer(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd  = prdata;
        err = pslverr;
        // Released lines no longer show the old request
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;
        pwdata  <= ~wd;
    endtask
endmodule // csf_host_model

// file: tb/test_csf_status_flags.sv
// Self-checking bench for the codec status flag registers.
// Assumes the host model drives APB; status levels come from vector lv.
`timescale 1ns/10ps
module test_csf_status_flags;
    import csf_pkg::*;
    localparam logic [11:0] A_PWR  = {2'h0, IDX_PWR, 2'h0};
    localparam logic [11:0] A_SH   = {2'h0, IDX_SHORT, 2'h0};
    localparam logic [11:0] A_ST   = {2'h0, IDX_STICKY, 2'h0};
    localparam logic [11:0] A_LIVE = {2'h0, IDX_LIVE, 2'h0};
    localparam logic [11:0] A_CTRL = {2'h0, IDX_CTRL, 2'h0};
    localparam logic [11:0] A_BTN  = {2'h0, IDX_BTN_CLR, 2'h0};
    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq_pulse;
    logic [16:0] lv;
    logic [7:0]  st;
    logic        btn;
    logic [31:0] icnt = '0;
    logic [31:0] c0;
    int          fail_count;
    int          total_checks;
    int          cyc;

    csf_status_flags #(.IRQ_PULSE_CYCLES(8)) csf_status_flags_inst (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .left_dac_pwr(lv[0]), .right_dac_pwr(lv[1]),
        .mono_diff_line_out_pwr(lv[2]), .left_diff_line_out_pwr(lv[3]),
        .right_diff_line_out_pwr(lv[4]), .left_headphone_driver_pwr(lv[5]),
        .right_headphone_driver_pwr(lv[6]), .left_common_driver_pwr(lv[7]),
        .right_common_driver_pwr(lv[8]), .left_headphone_driver_short(lv[9]),
        .right_headphone_driver_short(lv[10]), .left_common_driver_short(lv[11]),
        .right_common_driver_short(lv[12]), .headset_present(lv[13]),
        .button_pressed(lv[14]), .left_noise_gate(lv[15]),
        .right_noise_gate(lv[16]), .irq_pulse(irq_pulse)
    );

    csf_host_model csf_host_model_inst (
        .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ==========================================================
    // Expected register images from the present levels
    function automatic logic [7:0] lvl(input logic [16:0] n);
        return {n[9], n[10], n[11], n[12], 2'b00, n[15], n[16]};
    endfunction
    function automatic logic [31:0] e_pwr();
        return {24'h0, lv[0], lv[1], lv[2], lv[3], lv[4], lv[5], lv[6], 1'b0};
    endfunction
    function automatic logic [31:0] e_sh();
        return {24'h0, lv[9], lv[10], lv[11], lv[12], lv[7], lv[8], 2'b00};
    endfunction
    function automatic logic [31:0] e_live();
        return {24'h0, lv[9], lv[10], lv[11], lv[12], btn, lv[13], lv[15], lv[16]};
    endfunction

    // ==========================================================
    // Compare, bus and stimulus tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic ee);
        logic [31:0] d;
        logic        er;
        csf_host_model_inst.xfer(1'b0, a, 32'h0, d, er);
        chk(d, e);
        chk({31'h0, er}, {31'h0, ee});
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        logic [31:0] d;
        logic        er;
        csf_host_model_inst.xfer(1'b1, a, wd, d, er);
        chk({31'h0, er}, 32'h0);
    endtask
    // New levels; wait out the two-flop synchroniser
    task automatic apply(input logic [16:0] n);
        @(posedge clk);
        st  = st | lvl(n) | {4'h0, n[14] & ~lv[14], n[13] ^ lv[13], 2'b00};
        btn = btn | (n[14] & ~lv[14]);
        lv <= n;
        repeat (4) @(posedge clk);
    endtask

    task end_of_test;
        $display("checks=%0d mismatches=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(negedge clk) begin
        if (irq_pulse === 1'b1)
            icnt <= icnt + 32'h1;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            end_of_test();
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        rst  = 1'b1;
        lv   = '0;
        st   = '0;
        btn  = 1'b0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (int r = 0; r < 4; r++) begin
            // Ones written to the four status registers are ignored; each reads zero
            wr(A_PWR + 12'(4 * r), 32'hFFFF_FFFC);
            rdc(A_PWR + 12'(4 * r), 32'h0, 1'b0);
        end
        rdc(12'h004, 32'h0, 1'b1);
        // Walk a single active level through every input
        for (int i = 0; i < 17; i++) begin
            apply(17'h1 << i);
            rdc(A_PWR, e_pwr(), 1'b0);
            rdc(A_SH, e_sh(), 1'b0);
            rdc(A_LIVE, e_live(), 1'b0);
            rdc(A_ST, {24'h0, st}, 1'b0);
            st = lvl(lv);
        end
        rdc(A_BTN, 32'h0, 1'b0);
        btn = 1'b0;
        rdc(A_LIVE, e_live(), 1'b0);
        // Continuous interrupt train until the sticky register is read
        apply(17'h0);
        rdc(A_ST, {24'h0, st}, 1'b0);
        st = lvl(lv);
        wr(A_CTRL, 32'h1);
        rdc(A_CTRL, 32'h1, 1'b0);
        apply(17'h1 << 15);
        c0 = icnt;
        repeat (32) @(posedge clk);
        chk(icnt - c0, 32'h4);
        apply(17'h0);
        rdc(A_ST, {24'h0, st}, 1'b0);
        st = lvl(lv);
        // A pulse may still leave on the read's own edge
        repeat (2) @(posedge clk);
        c0 = icnt;
        repeat (32) @(posedge clk);
        chk(icnt - c0, 32'h0);
        wr(A_CTRL, 32'h0);
        end_of_test();
    end
endmodule // test_csf_status_flags
